//--- pin_fault_supervisor.sv
// pin open and short fault supervisor
// How it works
// RL1: every pin fault restarts automatically, never latches off
// RL2: fet select high: first gate pulse over 2 us ends, flags short, 1.5 s delay
// RL3: fet select low: first pulse limit 2 us, or 1 us with small demag resistor
// RL4: sense at overcurrent on three consecutive pulses: open fault, 1.5 s delay
// RL5: 10 us after turn-on, bias below 14 V blocks switching, one lockout cycle
// RL6: bias above 15 V on three consecutive pulses gives one lockout cycle
// RL7: demag set pin short or open at turn-on gives lockout reset at once
// RL8: zvs delay set pin short or open at turn-on gives lockout reset at once
// RL9: auxiliary over-voltage held for 750 us gives lockout reset
// RL10: set pin checks run before switching; restart only on a later supply cycle
// RL11: consecutive counters clear on a clean pulse and on each lockout restart
`timescale 1ns/1ps
`default_nettype none
`include "pin_fault_map.svh"
module pin_fault_supervisor
   import pin_fault_pkg::*;
#(
   parameter int unsigned RESTART_CYC = `RESTART_DELAY_CYC,
   parameter int unsigned AUX_CYC = `AUX_OVP_CYC
)
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // supply and configuration comparators
   input wire logic supply_on,
   input wire logic fet_select_high,
   input wire logic demag_below_threshold,
   // gate request from the pwm core
   input wire logic gate_request,
   // pin comparators
   input wire logic cs_over_limit,
   input wire logic bias_below_14v,
   input wire logic bias_above_15v,
   input wire logic demag_pin_short,
   input wire logic demag_pin_open,
   input wire logic zvs_pin_short,
   input wire logic zvs_pin_open,
   input wire logic aux_over_voltage,
   // outputs
   output logic low_side_gate_pulse,
   output logic switching_allowed,
   output logic uvlo_restart,
   output logic fault_restart_delay,
   output logic cs_short_fault,
   output logic cs_open_fault
);
   // one timer width covers restart delay, aux filter and bias settle
   localparam int unsigned MAX_RA = (RESTART_CYC > AUX_CYC) ? RESTART_CYC : AUX_CYC;
   localparam int unsigned MAX_ALL = (MAX_RA > `BIAS_SAMPLE_CYC) ? MAX_RA : `BIAS_SAMPLE_CYC;
   localparam int unsigned W = $clog2(MAX_ALL + 1);

   // =========================================
   // input synchronisers
   localparam int N = 12;
   logic [N-1:0] raw, s1_reg, s2_reg;
   assign raw = {supply_on, fet_select_high, demag_below_threshold, gate_request,
      cs_over_limit, bias_below_14v, bias_above_15v, demag_pin_short, demag_pin_open,
      zvs_pin_short, zvs_pin_open, aux_over_voltage};
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_reg <= '0;
         s2_reg <= '0;
      end
      else
      begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
      end
   end
   logic sup_on, fet_hi, dm_small, greq, cs_hi, b_lo, b_hi, dm_sh, dm_op, zv_sh, zv_op, aux_hi;
   assign {sup_on, fet_hi, dm_small, greq, cs_hi, b_lo, b_hi, dm_sh, dm_op,
      zv_sh, zv_op, aux_hi} = s2_reg;

   // =========================================
   // three-pulse counters
   pulse_fault_if cs_if ();
   pulse_fault_if bias_if ();
   consec_pulse_counter u_cs_cnt (.core_clk(core_clk), .rst_b(rst_b), .pf(cs_if.cnt));
   consec_pulse_counter u_bias_cnt (.core_clk(core_clk), .rst_b(rst_b), .pf(bias_if.cnt));

   // =========================================
   // state
   phase_e st_reg, st_next;
   logic [W-1:0] tmr_reg, tmr_next;
   logic gate_reg, gate_next;
   logic first_reg, first_next;
   logic cs_seen_reg, cs_seen_next, b_seen_reg, b_seen_next;
   logic cs_sh_reg, cs_sh_next, cs_op_reg, cs_op_next;
   logic [W-1:0] aux_reg, aux_next;
   logic pulse_end, limit_hit;
   logic [W-1:0] limit;

   assign limit = (fet_hi || !dm_small) ? W'(`LONG_CYC) : W'(`SHORT_CYC); // RL2 RL3
   assign limit_hit = first_reg && gate_reg && (tmr_reg >= limit - W'(1));
   assign pulse_end = gate_reg && !gate_next;

   assign cs_if.pulse_end = pulse_end;
   assign cs_if.cond = cs_seen_reg || cs_hi;
   assign cs_if.clear = (st_reg != ST_RUN);
   assign bias_if.pulse_end = pulse_end;
   assign bias_if.cond = b_seen_reg || b_hi;
   assign bias_if.clear = (st_reg != ST_RUN); // RL11

   always_comb
   begin
      st_next = st_reg;
      tmr_next = tmr_reg;
      gate_next = 1'b0;
      first_next = first_reg;
      cs_seen_next = cs_seen_reg;
      b_seen_next = b_seen_reg;
      cs_sh_next = cs_sh_reg;
      cs_op_next = cs_op_reg;
      aux_next = (aux_hi && st_reg == ST_RUN) ? aux_reg + W'(1) : '0;
      unique case (st_reg)
         ST_OFF:
         begin
            tmr_next = '0;
            if (sup_on)
            begin
               if (dm_sh || dm_op || zv_sh || zv_op)
               begin
                  st_next = ST_UVLO; // RL7 RL8 RL10
               end
               else
               begin
                  st_next = ST_SETTLE;
               end
            end
         end
         ST_SETTLE:
         begin
            tmr_next = tmr_reg + W'(1);
            if (tmr_reg == W'(`BIAS_SAMPLE_CYC - 1))
            begin
               tmr_next = '0;
               first_next = 1'b1;
               cs_sh_next = 1'b0;
               cs_op_next = 1'b0;
               cs_seen_next = 1'b0; // RL11
               b_seen_next = 1'b0; // RL11
               st_next = b_lo ? ST_UVLO : ST_RUN; // RL5
            end
         end
         ST_RUN:
         begin
            gate_next = greq && !limit_hit; // RL2 RL3
            if (gate_reg)
            begin
               tmr_next = tmr_reg + W'(1);
               cs_seen_next = cs_seen_reg || cs_hi; // RL4
               b_seen_next = b_seen_reg || b_hi; // RL6
            end
            if (pulse_end)
            begin
               first_next = 1'b0;
               tmr_next = '0;
               cs_seen_next = 1'b0;
               b_seen_next = 1'b0;
            end
            if (limit_hit)
            begin
               cs_sh_next = 1'b1;
               st_next = ST_DELAY; // RL2
               tmr_next = '0;
            end
            else if (cs_if.trip)
            begin
               cs_op_next = 1'b1;
               st_next = ST_DELAY; // RL4
               tmr_next = '0;
            end
            else if (bias_if.trip || aux_reg >= W'(AUX_CYC - 1))
            begin
               st_next = ST_UVLO; // RL6 RL9
            end
            else if (!sup_on)
            begin
               st_next = ST_OFF;
            end
         end
         ST_DELAY:
         begin
            tmr_next = tmr_reg + W'(1);
            if (tmr_reg == W'(RESTART_CYC - 1))
            begin
               st_next = ST_UVLO; // RL1
            end
         end
         ST_UVLO:
         begin
            tmr_next = '0;
            if (!sup_on)
            begin
               st_next = ST_OFF; // RL1 RL10
            end
         end
         default:
         begin
            st_next = ST_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         st_reg <= ST_OFF;
         tmr_reg <= '0;
         gate_reg <= 1'b0;
         first_reg <= 1'b0;
         cs_seen_reg <= 1'b0;
         b_seen_reg <= 1'b0;
         cs_sh_reg <= 1'b0;
         cs_op_reg <= 1'b0;
         aux_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
         tmr_reg <= tmr_next;
         gate_reg <= gate_next;
         first_reg <= first_next;
         cs_seen_reg <= cs_seen_next;
         b_seen_reg <= b_seen_next;
         cs_sh_reg <= cs_sh_next;
         cs_op_reg <= cs_op_next;
         aux_reg <= aux_next;
      end
   end

   assign low_side_gate_pulse = gate_reg;
   assign switching_allowed = (st_reg == ST_RUN);
   assign uvlo_restart = (st_reg == ST_UVLO);
   assign fault_restart_delay = (st_reg == ST_DELAY);
   assign cs_short_fault = cs_sh_reg;
   assign cs_open_fault = cs_op_reg;

   // =========================================
   // checks
   first_pulse_cap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      limit_hit |=> !gate_reg && st_reg == ST_DELAY && cs_sh_reg) // RL2
      else $error("first pulse not cut");
   short_limit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (first_reg && gate_reg && !fet_hi && dm_small && tmr_reg == W'(`SHORT_CYC - 1))
      |-> limit_hit) // RL3
      else $error("1 us limit missed");
   cs_open_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_reg == ST_RUN && cs_if.trip && !limit_hit) |=> st_reg == ST_DELAY && cs_op_reg) // RL4
      else $error("cs open not acted on");
   bias_sample_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_reg == ST_SETTLE && tmr_reg == W'(`BIAS_SAMPLE_CYC - 1) && b_lo) |=> uvlo_restart) // RL5
      else $error("bias open missed");
   bias_ov_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_reg == ST_RUN && bias_if.trip && !limit_hit && !cs_if.trip) |=> uvlo_restart) // RL6
      else $error("bias over-voltage missed");
   set_pins_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_reg == ST_OFF && sup_on && (dm_sh || dm_op || zv_sh || zv_op)) |=> uvlo_restart) // RL7 RL8
      else $error("set pin fault missed");
   no_gate_idle_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (st_reg != ST_RUN) |=> !low_side_gate_pulse) // RL10
      else $error("gate outside run");
   delay_exit_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      $fell(fault_restart_delay) |-> uvlo_restart) // RL1
      else $error("delay not followed by restart");
endmodule // pin_fault_supervisor
`default_nettype wire

//--- pin_fault_map.svh
// timing and threshold constants of the pin fault supervisor
`ifndef PIN_FAULT_MAP_SVH
`define PIN_FAULT_MAP_SVH
`define CLK_MHZ 50
`define FIRST_PULSE_LONG_NS 2000
`define FIRST_PULSE_SHORT_NS 1000
`define LONG_CYC (`FIRST_PULSE_LONG_NS * `CLK_MHZ / 1000)
`define SHORT_CYC (`FIRST_PULSE_SHORT_NS * `CLK_MHZ / 1000)
`define BIAS_SAMPLE_NS 10000
`define BIAS_SAMPLE_CYC (`BIAS_SAMPLE_NS * `CLK_MHZ / 1000)
`define AUX_OVP_US 750
`define AUX_OVP_CYC (`AUX_OVP_US * `CLK_MHZ)
`define RESTART_DELAY_MS 1500
`define RESTART_DELAY_CYC (`RESTART_DELAY_MS * 1000 * `CLK_MHZ)
`define CONSEC_PULSES 3
`endif

//--- pin_fault_pkg.sv
// types of the pin fault supervisor
`default_nettype none
package pin_fault_pkg;
   typedef enum logic [2:0] {ST_OFF, ST_SETTLE, ST_RUN, ST_DELAY, ST_UVLO} phase_e;
   typedef logic [1:0] pulse_cnt_t;
endpackage
`default_nettype wire

//--- pulse_fault_if.sv
// carrier between supervisor and three-pulse fault counters
`timescale 1ns/1ps
`default_nettype none
interface pulse_fault_if;
   logic pulse_end;
   logic cond;
   logic clear;
   logic trip;
   modport sup (output pulse_end, output cond, output clear, input trip);
   modport cnt (input pulse_end, input cond, input clear, output trip);
endinterface
`default_nettype wire

//--- consec_pulse_counter.sv
// counts consecutive gate pulses that show a fault condition
`timescale 1ns/1ps
`default_nettype none
module consec_pulse_counter
   import pin_fault_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // link to supervisor
   pulse_fault_if.cnt pf
);
`include "pin_fault_map.svh"
   pulse_cnt_t count_reg, count_next;
   logic trip_reg, trip_next;

   always_comb
   begin
      count_next = count_reg;
      trip_next = 1'b0;
      if (pf.clear)
      begin
         count_next = 2'h0; // RL11
      end
      else if (pf.pulse_end)
      begin
         if (!pf.cond)
         begin
            count_next = 2'h0; // RL11
         end
         else if (count_reg == 2'(`CONSEC_PULSES - 1))
         begin
            count_next = 2'h0;
            trip_next = 1'b1;
         end
         else
         begin
            count_next = count_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         count_reg <= 2'h0;
         trip_reg <= 1'b0;
      end
      else
      begin
         count_reg <= count_next;
         trip_reg <= trip_next;
      end
   end

   assign pf.trip = trip_reg;

   // =========================================
   // checks
   trip_after_three_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (pf.pulse_end && pf.cond && !pf.clear && count_reg == 2'h2) |=> pf.trip) // RL4 RL6
      else $error("three-pulse trip missed");
endmodule // consec_pulse_counter
`default_nettype wire

//--- stage_model.sv
// behavioural power stage and sense network at the far side
`timescale 1ns/1ps
`default_nettype none
module stage_model
(
   // gate from the supervisor
   input wire logic low_side_gate_pulse,
   // fault injection from the bench
   input wire logic cs_open_mode,
   input wire logic ov_mode,
   // comparator results
   output logic cs_over_limit,
   output logic bias_above_15v
);
   // open sense pin floats above the limit while the switch conducts
   assign cs_over_limit = cs_open_mode & low_side_gate_pulse;
   // bias overshoot follows each switching pulse
   assign bias_above_15v = ov_mode & low_side_gate_pulse;
endmodule // stage_model
`default_nettype wire

//--- tb.sv
// self-checking bench of the pin fault supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pin_fault_pkg::*;
   localparam int unsigned RC = 200;
   localparam int unsigned AC = 20;
   logic core_clk, rst_b, supply_on, fet_select_high, demag_below_threshold, gate_request;
   logic bias_below_14v, demag_pin_short, demag_pin_open, zvs_pin_short, zvs_pin_open;
   logic aux_over_voltage, cs_open_mode, ov_mode;
   logic cs_over_limit, bias_above_15v, low_side_gate_pulse, switching_allowed;
   logic uvlo_restart, fault_restart_delay, cs_short_fault, cs_open_fault;
   int n_fail = 0;
   int cmp_count = 0;
   pin_fault_supervisor #(.RESTART_CYC(RC), .AUX_CYC(AC)) dut (.core_clk(core_clk),
      .rst_b(rst_b), .supply_on(supply_on), .fet_select_high(fet_select_high),
      .demag_below_threshold(demag_below_threshold), .gate_request(gate_request),
      .cs_over_limit(cs_over_limit), .bias_below_14v(bias_below_14v),
      .bias_above_15v(bias_above_15v), .demag_pin_short(demag_pin_short),
      .demag_pin_open(demag_pin_open), .zvs_pin_short(zvs_pin_short),
      .zvs_pin_open(zvs_pin_open), .aux_over_voltage(aux_over_voltage),
      .low_side_gate_pulse(low_side_gate_pulse), .switching_allowed(switching_allowed),
      .uvlo_restart(uvlo_restart), .fault_restart_delay(fault_restart_delay),
      .cs_short_fault(cs_short_fault), .cs_open_fault(cs_open_fault));
   stage_model stage (.low_side_gate_pulse(low_side_gate_pulse), .cs_open_mode(cs_open_mode),
      .ov_mode(ov_mode), .cs_over_limit(cs_over_limit), .bias_above_15v(bias_above_15v));
   // ==========
   // shared tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("fails %0d compares %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // request held n cycles, gate high cycles counted in w
   task automatic pulse(input int n, output logic [7:0] w);
      w = 8'h00;
      gate_request = 1'b1;
      for (int i = 0; i < n + 8; i++)
      begin
         @(negedge core_clk);
         if (i == n - 1)
            gate_request = 1'b0;
         w = w + 8'(low_side_gate_pulse);
      end
   endtask
   task automatic power_up();
      supply_on = 1'b0;
      repeat (4) @(negedge core_clk);
      supply_on = 1'b1;
      repeat (400) @(negedge core_clk);
      chk(8'(switching_allowed), 8'h00);
      for (int i = 0; i < 300 && !(switching_allowed || uvlo_restart); i++)
         @(negedge core_clk);
   endtask
   // ==========
   // scenarios
   task automatic s_norm();
      logic [7:0] w;
      fet_select_high = 1'b1;
      power_up();
      chk(8'(switching_allowed), 8'h01);
      pulse(20, w);
      chk(w, 8'h14);
      pulse(150, w);
      chk(w, 8'h96);
      chk(8'(cs_short_fault), 8'h00);
   endtask
   task automatic s_first();
      logic [7:0] w;
      logic [1:0] cfg [3] = '{2'b10, 2'b00, 2'b01};
      logic [7:0] lim [3] = '{8'h64, 8'h64, 8'h32};
      for (int k = 0; k < 3; k++)
      begin
         fet_select_high = cfg[k][1];
         demag_below_threshold = cfg[k][0];
         power_up();
         pulse(150, w);
         chk(w, lim[k]);
         chk(8'(cs_short_fault), 8'h01);
         chk(8'(fault_restart_delay), 8'h01);
         repeat (RC + 10) @(negedge core_clk);
         chk(8'(uvlo_restart), 8'h01);
      end
      demag_below_threshold = 1'b0;
   endtask
   // bad, bad, clean, bad, bad, bad: only the last may trip
   task automatic s_three(input logic ov);
      logic [7:0] w;
      fet_select_high = 1'b1;
      power_up();
      pulse(20, w);
      for (int p = 0; p < 6; p++)
      begin
         if (ov)
            ov_mode = (p != 2);
         else
            cs_open_mode = (p != 2);
         pulse(20, w);
         chk(8'(ov ? uvlo_restart : cs_open_fault), 8'(p == 5));
      end
      if (!ov)
      begin
         chk(8'(fault_restart_delay), 8'h01);
         repeat (RC + 10) @(negedge core_clk);
         chk(8'(uvlo_restart), 8'h01);
      end
      cs_open_mode = 1'b0;
      ov_mode = 1'b0;
   endtask
   task automatic s_pins();
      for (int k = 0; k < 5; k++)
      begin
         {bias_below_14v, demag_pin_short, demag_pin_open, zvs_pin_short, zvs_pin_open} =
            5'(5'h10 >> k);
         power_up();
         chk(8'(uvlo_restart), 8'h01);
         chk(8'(switching_allowed), 8'h00);
      end
      {bias_below_14v, demag_pin_short, demag_pin_open, zvs_pin_short, zvs_pin_open} = 5'h00;
      power_up();
      chk(8'(switching_allowed), 8'h01);
   endtask
   task automatic s_aux();
      power_up();
      aux_over_voltage = 1'b1;
      repeat (AC - 5) @(negedge core_clk);
      aux_over_voltage = 1'b0;
      repeat (5) @(negedge core_clk);
      chk(8'(uvlo_restart), 8'h00);
      aux_over_voltage = 1'b1;
      repeat (AC + 5) @(negedge core_clk);
      chk(8'(uvlo_restart), 8'h01);
      aux_over_voltage = 1'b0;
   endtask
   // ==========
   // clock, watchdog, main sequence
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial
   begin
      #600000;
      n_fail++;
      complete_run();
   end
   initial
   begin
      {rst_b, supply_on, fet_select_high, demag_below_threshold, gate_request} = 5'h00;
      {bias_below_14v, demag_pin_short, demag_pin_open, zvs_pin_short, zvs_pin_open} = 5'h00;
      {aux_over_voltage, cs_open_mode, ov_mode} = 3'h0;
      repeat (2) @(negedge core_clk);
      rst_b = 1'b1;
      s_norm();
      s_first();
      s_three(1'b0);
      s_three(1'b1);
      s_pins();
      s_aux();
      complete_run();
   end
endmodule // tb
`default_nettype wire
